// *** core/gpm_monitor.sv ***
// Generator protection monitor: persistence checks, events, AHB-Lite registers.
// Assumes measurements arrive on this clock; status pins are asynchronous.
// Contract
// - Voltage unbalance: fuel on, three phases, tolerance
// - Line voltage pair difference over percent, delayed
// - Phase check setting adds line-neutral unbalance
// - Protections drive both protection outputs
// - Current unbalance: three phases, running, generator currents
// - Current pair difference over percent, delayed
// - Oil temperature: measured, after mask, not start/stop
// - Oil temperature above threshold for delay
// - Phase sequence: running, three phases, tolerance, breaker open
// - Rotation mismatch for half second
// - Any voltage below percent for delay
// - Manual mode needs breaker closed or option bit
// - Level checks use line voltages, optionally neutral; first line-neutral only when not three-phase
// - Clock invalid with schedule; cleared by setting clock
// - Frequency below percent for delay
// - Running, any voltage above percent for delay
// - Running, frequency above percent for delay
// - Negative reactive power beyond threshold for delay
// - CAN enabled and bus-off raises link fault
`timescale 1ns/100ps
module gpm_monitor
#(
   parameter int TICK_DIV = gpm_pkg::TICK_CYCLES
)
(
   // Clock and reset
   input  wire logic                   clock,
   input  wire logic                   reset,
   // AHB-Lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   // Asynchronous status pins
   input  wire logic [gpm_pkg::NPIN-1:0] status_pins,
   // Measurements, same clock
   input  wire logic [47:0]            volt_ll,
   input  wire logic [47:0]            volt_ln,
   input  wire logic [47:0]            curr_ph,
   input  wire logic [15:0]            freq,
   input  wire logic [15:0]            oil_temp,
   input  wire logic signed [15:0]     kvar_total,
   input  wire logic [1:0]             rotation,
   input  wire logic [1:0]             mains_rotation,
   // Event outputs
   output logic                        protection_output_a,
   output logic                        protection_output_b,
   output logic [gpm_pkg::NEV-1:0]     events,
   output logic [1:0]                  can_severity
);
   import gpm_pkg::*;

   function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
      absdiff = (a > b) ? a - b : b - a;
   endfunction

   // Value times 100 above percent times rated
   function automatic logic pct_over(input logic [15:0] v, input logic [7:0] pct,
                                     input logic [15:0] rated);
      pct_over = (32'(v) * 32'd100) > (32'(pct) * 32'(rated));
   endfunction

   function automatic logic pct_under(input logic [15:0] v, input logic [7:0] pct,
                                      input logic [15:0] rated);
      pct_under = (32'(v) * 32'd100) < (32'(pct) * 32'(rated));
   endfunction

   function automatic logic unb3(input logic [47:0] x, input logic [7:0] pct,
                                 input logic [15:0] rated);
      unb3 = pct_over(absdiff(x[15:0], x[31:16]), pct, rated)
           | pct_over(absdiff(x[31:16], x[47:32]), pct, rated)
           | pct_over(absdiff(x[15:0], x[47:32]), pct, rated);
   endfunction

   logic [NPIN-1:0]  sync1_q;
   logic [NPIN-1:0]  pin_q;
   logic [31:0]      cfg_q;
   logic [31:0]      thr_v_q;
   logic [31:0]      thr_f_q;
   logic [31:0]      thr_x_q;
   logic [31:0]      dly_q [4];
   logic [31:0]      rated_q;
   logic [31:0]      rated2_q;
   logic [NEV-1:0]   ev_q;
   logic             wr_pend_q;
   logic [7:0]       wr_addr_q;
   logic [31:0]      tick_cnt_q;
   logic             tick_q;
   logic [15:0]      mask_cnt_q;
   logic [15:0]      tmr_q [NTIMED];
   logic [NTIMED-1:0] trip;
   logic [NTIMED-1:0] cond;
   logic [15:0]      delay [NTIMED];
   logic             addr_ok;
   logic [31:0]      rd_mux;

   // Two-flop synchronisers for pins
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         sync1_q <= '0;
         pin_q   <= '0;
      end
      else
      begin
         sync1_q <= status_pins;
         pin_q   <= sync1_q;
      end
   end

   // Configuration fields
   logic [1:0]  phases;
   logic        phvchk;
   logic [1:0]  rot_req;
   logic [7:0]  man_opt;
   logic [15:0] rated_v;
   logic [15:0] rated_f;
   logic [15:0] rated_i;
   logic [15:0] mask_time;
   logic        running;
   logic        three;
   logic        gen_curr;
   logic        man_ok;
   logic        mask_done;
   logic [47:0] vsel;
   logic [2:0]  vn;

   assign phases    = cfg_q[CFG_PHASES_LSB +: 2];
   assign phvchk    = cfg_q[CFG_PHVCHK_BIT];
   assign rot_req   = cfg_q[CFG_ROT_LSB +: 2];
   assign man_opt   = cfg_q[CFG_MANOPT_LSB +: 8];
   assign rated_v   = rated_q[15:0];
   assign rated_f   = rated_q[31:16];
   assign rated_i   = rated2_q[15:0];
   assign mask_time = rated2_q[31:16];
   assign running   = pin_q[PIN_FUEL] & ~pin_q[PIN_SSP];
   assign three     = (phases == THREE_PHASE);
   assign gen_curr  = pin_q[PIN_CTGEN] | pin_q[PIN_BRK];
   assign man_ok    = ~pin_q[PIN_MAN] | pin_q[PIN_BRK] | man_opt[MANOPT_BRK_BIT];
   assign mask_done = (mask_cnt_q >= mask_time);
   assign vsel      = three ? volt_ll : volt_ln;
   assign vn        = three ? 3'h7 : 3'h1;

   // Millisecond tick
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         tick_cnt_q <= ZERO_RESET;
         tick_q     <= 1'b0;
      end
      else if (tick_cnt_q >= 32'(TICK_DIV - 1))
      begin
         tick_cnt_q <= ZERO_RESET;
         tick_q     <= 1'b1;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 32'h1;
         tick_q     <= 1'b0;
      end
   end

   // Mask time from engine start
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         mask_cnt_q <= 16'h0000;
      else if (!running)
         mask_cnt_q <= 16'h0000;
      else if (tick_q && !mask_done)
         mask_cnt_q <= mask_cnt_q + 16'h1;
   end

   // Level comparisons over the selected voltages
   logic any_low;
   logic any_high;
   always_comb
   begin
      any_low  = 1'b0;
      any_high = 1'b0;
      for (int k = 0; k < 3; k++)
      begin
         if (vn[k])
         begin
            any_low  = any_low | pct_under(vsel[16*k +: 16], thr_v_q[23:16], rated_v);
            any_high = any_high | pct_over(vsel[16*k +: 16], thr_v_q[31:24], rated_v);
         end
         if (three && phvchk)
         begin
            any_low  = any_low | pct_under(volt_ln[16*k +: 16], thr_v_q[23:16], rated_v);
            any_high = any_high | pct_over(volt_ln[16*k +: 16], thr_v_q[31:24], rated_v);
         end
      end
   end

   // Trip and enable conditions
   logic [1:0] rot_want;
   assign rot_want = (rot_req == ROT_AS_MAINS) ? mains_rotation : rot_req;
   always_comb
   begin
      cond[EV_VUNB]  = running & three & pin_q[PIN_TOL];
      trip[EV_VUNB]  = unb3(volt_ll, thr_v_q[7:0], rated_v)
                     | (phvchk & unb3(volt_ln, thr_v_q[7:0], rated_v));
      cond[EV_IUNB]  = running & three & gen_curr;
      trip[EV_IUNB]  = unb3(curr_ph, thr_v_q[15:8], rated_i);
      cond[EV_OIL]   = pin_q[PIN_OILOK] & running & mask_done;
      trip[EV_OIL]   = oil_temp > thr_f_q[31:16];
      cond[EV_PHSEQ] = running & three & pin_q[PIN_TOL] & ~pin_q[PIN_BRK]
                     & (rot_req != ROT_OFF);
      trip[EV_PHSEQ] = rotation != rot_want;
      cond[EV_VLOW]  = running & pin_q[PIN_TOL] & man_ok;
      trip[EV_VLOW]  = any_low;
      cond[EV_FLOW]  = running & pin_q[PIN_TOL] & man_ok;
      trip[EV_FLOW]  = pct_under(freq, thr_f_q[7:0], rated_f);
      cond[EV_VHIGH] = running;
      trip[EV_VHIGH] = any_high;
      cond[EV_FHIGH] = running;
      trip[EV_FHIGH] = pct_over(freq, thr_f_q[15:8], rated_f);
      cond[EV_EXC]   = running & gen_curr;
      trip[EV_EXC]   = (kvar_total < 16'sh0000)
                     & (32'(-32'(kvar_total)) > 32'(thr_x_q[15:0]));
   end

   // Delay per check; phase sequence uses a fixed filter
   always_comb
   begin
      delay[EV_VUNB]  = dly_q[0][15:0];
      delay[EV_IUNB]  = dly_q[0][31:16];
      delay[EV_OIL]   = dly_q[1][15:0];
      delay[EV_PHSEQ] = PHSEQ_FILTER_MS;
      delay[EV_VLOW]  = dly_q[1][31:16];
      delay[EV_FLOW]  = dly_q[2][15:0];
      delay[EV_VHIGH] = dly_q[2][31:16];
      delay[EV_FHIGH] = dly_q[3][15:0];
      delay[EV_EXC]   = dly_q[3][31:16];
   end

   // Persistence timers
   genvar g;
   generate
      for (g = 0; g < NTIMED; g++)
      begin : g_tmr
         always_ff @(posedge clock or posedge reset)
         begin
            if (reset)
               tmr_q[g] <= 16'h0000;
            else if (!(cond[g] && trip[g]) || delay[g] == 16'h0000)
               tmr_q[g] <= 16'h0000;
            else if (tick_q && tmr_q[g] < delay[g])
               tmr_q[g] <= tmr_q[g] + 16'h1;
         end
      end
   endgenerate

   // AHB-Lite address phase decode
   logic take;
   assign take    = hsel & htrans[1] & hready;
   assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00)
                  && (haddr[7:0] <= OFS_RATED2);

   always_comb
   begin
      unique case (haddr[7:0])
         OFS_CFG:    rd_mux = cfg_q;
         OFS_THR_V:  rd_mux = thr_v_q;
         OFS_THR_F:  rd_mux = thr_f_q;
         OFS_THR_X:  rd_mux = thr_x_q;
         OFS_DLY_A:  rd_mux = dly_q[0];
         OFS_DLY_B:  rd_mux = dly_q[1];
         OFS_DLY_C:  rd_mux = dly_q[2];
         OFS_DLY_D:  rd_mux = dly_q[3];
         OFS_STATUS: rd_mux = {21'h000000, ev_q};
         OFS_RATED:  rd_mux = rated_q;
         OFS_RATED2: rd_mux = rated2_q;
         default:    rd_mux = ZERO_RESET;
      endcase
   end

   // Bus answers, zero wait state
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= ZERO_RESET;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_q <= take & hwrite & addr_ok;
         if (take)
            wr_addr_q <= haddr[7:0];
         if (take && !hwrite)
            hrdata <= addr_ok ? rd_mux : ZERO_RESET;
      end
   end

   // Register writes in data phase
   logic wr_status;
   assign wr_status = wr_pend_q && (wr_addr_q == OFS_STATUS);
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         cfg_q    <= CFG_RESET;
         thr_v_q  <= ZERO_RESET;
         thr_f_q  <= ZERO_RESET;
         thr_x_q  <= ZERO_RESET;
         rated_q  <= ZERO_RESET;
         rated2_q <= ZERO_RESET;
         for (int k = 0; k < 4; k++)
            dly_q[k] <= ZERO_RESET;
      end
      else if (wr_pend_q)
      begin
         unique case (wr_addr_q)
            OFS_CFG:    cfg_q    <= hwdata;
            OFS_THR_V:  thr_v_q  <= hwdata;
            OFS_THR_F:  thr_f_q  <= hwdata;
            OFS_THR_X:  thr_x_q  <= hwdata;
            OFS_DLY_A:  dly_q[0] <= hwdata;
            OFS_DLY_B:  dly_q[1] <= hwdata;
            OFS_DLY_C:  dly_q[2] <= hwdata;
            OFS_DLY_D:  dly_q[3] <= hwdata;
            OFS_RATED:  rated_q  <= hwdata;
            OFS_RATED2: rated2_q <= hwdata;
            default:    ;
         endcase
      end
   end

   // Sticky events; set wins over write-one-to-clear
   logic [NEV-1:0] ev_set;
   logic [NEV-1:0] ev_clr;
   always_comb
   begin
      ev_set = '0;
      for (int k = 0; k < NTIMED; k++)
         ev_set[k] = (delay[k] != 16'h0000) && (tmr_q[k] >= delay[k]);
      ev_set[EV_CLK] = ~pin_q[PIN_CLKOK] & cfg_q[CFG_SCHED_BIT];
      ev_set[EV_CAN] = cfg_q[CFG_CANEN_BIT] & pin_q[PIN_BOFF];
      ev_clr = wr_status ? hwdata[NEV-1:0] : '0;
      ev_clr[EV_CLK] = pin_q[PIN_CLKOK];
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         ev_q <= '0;
      else
         ev_q <= ev_set | (ev_q & ~ev_clr);
   end

   // Outputs from flops
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         protection_output_a <= 1'b0;
         protection_output_b <= 1'b0;
         events              <= '0;
         can_severity        <= 2'h0;
      end
      else
      begin
         protection_output_a <= |(ev_q & PROT_OUT_MASK);
         protection_output_b <= |(ev_q & PROT_OUT_MASK);
         events              <= ev_q;
         can_severity        <= cfg_q[CFG_CANACT_LSB +: 2];
      end
   end
endmodule

// *** include/gpm_pkg.sv ***
// Package for the generator protection monitor: offsets, fields, timing.
// Assumes a 100 MHz clock and a 32-bit AHB-Lite register bus.
package gpm_pkg;
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          TICK_TIME_NS   = 1000000;
   localparam int          TICK_CYCLES    = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam logic [15:0] PHSEQ_FILTER_MS = 16'h01F4;

   localparam logic [7:0] OFS_CFG    = 8'h00;
   localparam logic [7:0] OFS_THR_V  = 8'h04;
   localparam logic [7:0] OFS_THR_F  = 8'h08;
   localparam logic [7:0] OFS_THR_X  = 8'h0C;
   localparam logic [7:0] OFS_DLY_A  = 8'h10;
   localparam logic [7:0] OFS_DLY_B  = 8'h14;
   localparam logic [7:0] OFS_DLY_C  = 8'h18;
   localparam logic [7:0] OFS_DLY_D  = 8'h1C;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] OFS_RATED  = 8'h24;
   localparam logic [7:0] OFS_RATED2 = 8'h28;

   localparam int         CFG_PHASES_LSB = 0;
   localparam int         CFG_PHVCHK_BIT = 2;
   localparam int         CFG_ROT_LSB    = 4;
   localparam int         CFG_MANOPT_LSB = 8;
   localparam int         MANOPT_BRK_BIT = 2;
   localparam int         CFG_CANACT_LSB = 16;
   localparam int         CFG_CANEN_BIT  = 18;
   localparam int         CFG_SCHED_BIT  = 19;
   localparam logic [1:0] THREE_PHASE    = 2'h3;
   localparam logic [1:0] ROT_OFF        = 2'h0;
   localparam logic [1:0] ROT_AS_MAINS   = 2'h3;

   localparam logic [31:0] CFG_RESET  = 32'h0000_0003;
   localparam logic [31:0] ZERO_RESET = 32'h0000_0000;

   localparam int PIN_FUEL  = 0;
   localparam int PIN_SSP   = 1;
   localparam int PIN_TOL   = 2;
   localparam int PIN_BRK   = 3;
   localparam int PIN_CTGEN = 4;
   localparam int PIN_MAN   = 5;
   localparam int PIN_OILOK = 6;
   localparam int PIN_CLKOK = 7;
   localparam int PIN_BOFF  = 8;
   localparam int NPIN      = 9;

   localparam int EV_VUNB  = 0;
   localparam int EV_IUNB  = 1;
   localparam int EV_OIL   = 2;
   localparam int EV_PHSEQ = 3;
   localparam int EV_VLOW  = 4;
   localparam int EV_FLOW  = 5;
   localparam int EV_VHIGH = 6;
   localparam int EV_FHIGH = 7;
   localparam int EV_EXC   = 8;
   localparam int EV_CLK   = 9;
   localparam int EV_CAN   = 10;
   localparam int NTIMED   = 9;
   localparam int NEV      = 11;
   localparam logic [NEV-1:0] PROT_OUT_MASK = 11'h1FB;
endpackage

// *** test/gpm_genset_model.sv ***
// Genset model: healthy measurements, one selectable distortion at a time.
// Assumes rated 400 V, 50.0 Hz, 100 A; pins pass straight from the bench.
`timescale 1ns/100ps
module gpm_genset_model
(
   // Bench commands
   input wire logic [8:0]                pins,
   input wire logic [3:0]                fault,
   input wire logic [1:0]                jit,
   // Measurements and status
   output logic [gpm_pkg::NPIN-1:0]      status_pins,
   output logic [47:0]                   volt_ll,
   output logic [47:0]                   volt_ln,
   output logic [47:0]                   curr_ph,
   output logic [15:0]                   freq,
   output logic [15:0]                   oil_temp,
   output logic signed [15:0]            kvar_total,
   output logic [1:0]                    rotation,
   output logic [1:0]                    mains_rotation
);
   import gpm_pkg::*;
   always_comb
   begin
      status_pins = pins;
      volt_ll = {3{16'h0190}};
      volt_ll[15:0] = 16'h0190 + 16'(jit);
      volt_ln = {3{16'h0190}};
      curr_ph = {3{16'h0064}};
      freq = 16'h01F4;
      oil_temp = 16'h0050;
      kvar_total = 16'sh000A;
      rotation = 2'h1;
      mains_rotation = 2'h1;
      case (fault)
         4'h1: volt_ll[15:0] = 16'h0168 + 16'(jit);
         4'h2: curr_ph[15:0] = 16'h003C;
         4'h3: oil_temp = 16'h0096;
         4'h4: rotation = 2'h2;
         4'h5: volt_ll = {3{16'h012C}};
         4'h6: freq = 16'h0190;
         4'h7: volt_ll = {3{16'h01CC}};
         4'h8: freq = 16'h0258;
         4'h9: kvar_total = -16'sh0064;
         4'hA: volt_ln[15:0] = 16'h0168;
         4'hB: volt_ln = {3{16'h012C}};
         default: ;
      endcase
   end
endmodule

// *** test/gpm_monitor_sva.sv ***
// Checker for the generator protection monitor: port-level assertions.
// Assumes it is bound to gpm_monitor; status pins pass two sync flops.
`timescale 1ns/100ps
module gpm_monitor_sva
(
   // Clock and reset
   input wire logic                      clock,
   input wire logic                      reset,
   // Watched outputs
   input wire logic                      hreadyout,
   input wire logic                      hresp,
   input wire logic                      protection_output_a,
   input wire logic                      protection_output_b,
   input wire logic [gpm_pkg::NEV-1:0]  events,
   // Watched inputs
   input wire logic [gpm_pkg::NPIN-1:0] status_pins,
   input wire logic signed [15:0]        kvar_total
);
   import gpm_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   wire logic prot = |(events & PROT_OUT_MASK);
   wire logic boff = status_pins[PIN_BOFF];
   wire logic clkok = status_pins[PIN_CLKOK];
   wire logic run = status_pins[PIN_FUEL] && !status_pins[PIN_SSP];

   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus stalled or error response");
   a_out_pair: assert property (protection_output_a == protection_output_b)
      else $error("protection outputs differ");
   a_out_rise: assert property ($rose(prot) |-> ##[0:1] protection_output_a)
      else $error("protection output not raised");
   a_out_drop: assert property (!prot [*2] |-> !protection_output_a)
      else $error("protection output without event");
   a_vunb_fuel: assert property ($rose(events[EV_VUNB]) |-> $past(run, 5))
      else $error("voltage unbalance without running engine");
   a_iunb_src: assert property ($rose(events[EV_IUNB]) |->
      $past(status_pins[PIN_CTGEN] || status_pins[PIN_BRK], 5))
      else $error("current unbalance without generator currents");
   a_oil_gate: assert property ($rose(events[EV_OIL]) |->
      $past(status_pins[PIN_OILOK] && !status_pins[PIN_SSP], 5))
      else $error("oil warning without measurement");
   a_seq_open: assert property ($rose(events[EV_PHSEQ]) |-> $past(!status_pins[PIN_BRK], 5))
      else $error("phase sequence with breaker closed");
   a_exc_neg: assert property ($rose(events[EV_EXC]) |-> $past(kvar_total[15], 3))
      else $error("excitation loss with positive reactive power");
   a_vhigh_run: assert property ($rose(events[EV_VHIGH]) |-> $past(run, 5))
      else $error("high voltage while not running");
   a_clk_clear: assert property ($fell(events[EV_CLK]) |->
      $past(clkok, 2) || $past(clkok, 3) || $past(clkok, 4))
      else $error("clock warning cleared while clock invalid");
   a_can_boff: assert property ($rose(events[EV_CAN]) |->
      $past(boff, 2) || $past(boff, 3) || $past(boff, 4))
      else $error("link fault without bus-off");

   c_vunb: cover property ($rose(events[EV_VUNB]));
   c_prot: cover property ($rose(protection_output_a));
   c_clk: cover property ($fell(events[EV_CLK]));
endmodule

bind gpm_monitor gpm_monitor_sva u_gpm_monitor_sva
(
   .clock               (clock),
   .reset               (reset),
   .hreadyout           (hreadyout),
   .hresp               (hresp),
   .protection_output_a (protection_output_a),
   .protection_output_b (protection_output_b),
   .events              (events),
   .status_pins         (status_pins),
   .kvar_total          (kvar_total)
);

// *** test/gpm_monitor_tb.sv ***
// Bench for the generator protection monitor over AHB-Lite.
// Assumes a 1 ms tick of 10 cycles; the genset model drives all measurements.
`timescale 1ns/100ps
module gpm_monitor_tb;
   import gpm_pkg::*;
   localparam logic [8:0] NORM = 9'h0D5;
   logic                  clock = 1'b0;
   logic                  reset = 1'b1;
   logic                  hsel = 1'b0;
   logic [31:0]           haddr = 32'h0;
   logic [1:0]            htrans = 2'h0;
   logic                  hwrite = 1'b0;
   logic [31:0]           hwdata = 32'h0;
   logic                  take = 1'b0;
   logic [3:0]            fault = 4'h0;
   logic [8:0]            pins = 9'h0D5;
   logic [1:0]            jit = 2'h0;
   logic [31:0]           rd_q[$];
   int                    num_errors = 0;
   int                    check_count = 0;
   wire logic             hreadyout, hresp, protection_output_a, protection_output_b;
   wire logic [31:0]      hrdata;
   wire logic [NEV-1:0]   events;
   wire logic [1:0]       can_severity, rotation, mains_rotation;
   wire logic [NPIN-1:0]  status_pins;
   wire logic [47:0]      volt_ll, volt_ln, curr_ph;
   wire logic [15:0]      freq, oil_temp;
   wire logic signed [15:0] kvar_total;

   gpm_monitor #(.TICK_DIV(10)) u_gpm_monitor
   (
      .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .status_pins(status_pins),
      .volt_ll(volt_ll), .volt_ln(volt_ln), .curr_ph(curr_ph), .freq(freq),
      .oil_temp(oil_temp), .kvar_total(kvar_total), .rotation(rotation),
      .mains_rotation(mains_rotation), .protection_output_a(protection_output_a),
      .protection_output_b(protection_output_b), .events(events),
      .can_severity(can_severity)
   );
   gpm_genset_model u_gpm_genset_model
   (
      .pins(pins), .fault(fault), .jit(jit), .status_pins(status_pins),
      .volt_ll(volt_ll), .volt_ln(volt_ln), .curr_ph(curr_ph), .freq(freq),
      .oil_temp(oil_temp), .kvar_total(kvar_total), .rotation(rotation),
      .mains_rotation(mains_rotation)
   );

   always #(CLK_PERIOD_NS / 2) clock = ~clock;
   always @(posedge clock) jit <= 2'($urandom_range(3, 0));
   always @(posedge clock)
      if (take)
         cmp_word(hrdata, rd_q.pop_front());

   task cmp_word(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %0t: got %h want %h", $time, g, e);
      end
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      take <= ~w;
      if (!w)
         rd_q.push_back(e);
      do @(posedge clock); while (hreadyout !== 1'b1);
      take <= 1'b0;
   endtask

   task scen(input logic [31:0] c, input logic [3:0] f, input logic [8:0] p,
             input logic [10:0] e, input int n);
      bus(1'b1, OFS_CFG, c, 32'h0);
      fault <= f;
      pins <= p;
      repeat (n) @(posedge clock);
      bus(1'b0, OFS_STATUS, 32'h0, {21'h0, e});
      cmp_word({31'h0, protection_output_a}, {31'h0, |(e & PROT_OUT_MASK)});
      cmp_word({21'h0, events}, {21'h0, e});
      fault <= 4'h0;
      pins <= NORM;
      bus(1'b1, OFS_CFG, c & ~32'h30, 32'h0);
      repeat (6) @(posedge clock);
      bus(1'b1, OFS_STATUS, 32'h7FF, 32'h0);
      bus(1'b0, OFS_STATUS, 32'h0, 32'h0);
      $display("test fault %0d pins %h done", f, p);
   endtask

   task give_verdict;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (50000) @(posedge clock);
      num_errors++;
      $display("ERROR %0t: timeout", $time);
      give_verdict();
   end

   initial
   begin
      void'($urandom(63665));
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      bus(1'b0, OFS_CFG, 32'h0, CFG_RESET);
      bus(1'b0, OFS_STATUS, 32'h0, ZERO_RESET);
      bus(1'b1, 8'h30, 32'hFFFFFFFF, 32'h0);
      bus(1'b0, 8'h30, 32'h0, 32'h0);
      bus(1'b1, OFS_THR_V, 32'h6E500A05, 32'h0);
      bus(1'b1, OFS_THR_F, 32'h00786E5A, 32'h0);
      bus(1'b1, OFS_THR_X, 32'h00000032, 32'h0);
      bus(1'b1, OFS_RATED, 32'h01F40190, 32'h0);
      bus(1'b1, OFS_RATED2, 32'h00020064, 32'h0);
      for (int i = 0; i < 4; i++)
         bus(1'b1, OFS_DLY_A + 8'(4 * i), 32'h00030003, 32'h0);
      bus(1'b0, OFS_THR_V, 32'h0, 32'h6E500A05);
      $display("test setup done");
      scen(32'h13, 4'h1, NORM, 11'h001, 100);
      scen(32'h13, 4'h1, NORM & ~9'h001, 11'h000, 100);
      scen(32'h12, 4'h1, NORM, 11'h000, 100);
      scen(32'h13, 4'h1, NORM & ~9'h004, 11'h000, 100);
      scen(32'h13, 4'h3, NORM, 11'h004, 100);
      scen(32'h13, 4'h3, NORM & ~9'h040, 11'h000, 100);
      scen(32'h13, 4'h2, NORM, 11'h002, 100);
      scen(32'h13, 4'h2, NORM & ~9'h010, 11'h000, 100);
      scen(32'h13, 4'h2, NORM & ~9'h010 | 9'h008, 11'h002, 100);
      scen(32'h13, 4'h5, NORM | 9'h020, 11'h000, 100);
      scen(32'h13, 4'h5, NORM | 9'h028, 11'h010, 100);
      scen(32'h413, 4'h5, NORM | 9'h020, 11'h010, 100);
      scen(32'h13, 4'h5, NORM, 11'h010, 100);
      scen(32'h17, 4'hA, NORM, 11'h001, 100);
      scen(32'h13, 4'hA, NORM, 11'h000, 100);
      scen(32'h17, 4'hB, NORM, 11'h010, 100);
      scen(32'h13, 4'hB, NORM, 11'h000, 100);
      scen(32'h13, 4'h6, NORM, 11'h020, 100);
      scen(32'h13, 4'h7, NORM, 11'h040, 100);
      scen(32'h13, 4'h7, NORM | 9'h002, 11'h000, 100);
      scen(32'h13, 4'h8, NORM, 11'h080, 100);
      scen(32'h13, 4'h9, NORM, 11'h100, 100);
      scen(32'h13, 4'h9, NORM & ~9'h010, 11'h000, 100);
      scen(32'h13, 4'h0, NORM | 9'h100, 11'h000, 8);
      scen(32'h70013, 4'h0, NORM | 9'h100, 11'h400, 8);
      cmp_word({30'h0, can_severity}, 32'h3);
      scen(32'h13, 4'h0, NORM & ~9'h080, 11'h000, 8);
      scen(32'h03, 4'h4, NORM, 11'h000, 5300);
      scen(32'h13, 4'h4, NORM, 11'h008, 5300);
      scen(32'h23, 4'h0, NORM, 11'h008, 5300);
      scen(32'h33, 4'h4, NORM, 11'h008, 5300);
      scen(32'h13, 4'h4, NORM | 9'h008, 11'h000, 5300);
      bus(1'b1, OFS_CFG, 32'h80013, 32'h0);
      pins <= NORM & ~9'h080;
      repeat (8) @(posedge clock);
      bus(1'b1, OFS_STATUS, 32'h200, 32'h0);
      bus(1'b0, OFS_STATUS, 32'h0, 32'h200);
      pins <= NORM;
      repeat (8) @(posedge clock);
      bus(1'b0, OFS_STATUS, 32'h0, 32'h0);
      $display("test clock warning done");
      bus(1'b1, OFS_CFG, 32'h13, 32'h0);
      repeat (10)
      begin
         fault <= 4'h1;
         repeat (12) @(posedge clock);
         fault <= 4'h0;
         repeat (2) @(posedge clock);
      end
      bus(1'b0, OFS_STATUS, 32'h0, 32'h0);
      $display("test persistence done");
      bus(1'b1, OFS_DLY_A, 32'h00030000, 32'h0);
      scen(32'h13, 4'h1, NORM, 11'h000, 100);
      give_verdict();
   end
endmodule
